/* File: core/tca_pkg.sv */
// package for the thermopile conversion averaging sequencer
// assumes a single 20 MHz clock and a synchronous active-high reset
package tca_pkg;

	localparam int          CLK_HZ          = 20000000;
	localparam int          CYCLE_MS        = 250;
	localparam int          CYCLE_CLKS      = CYCLE_MS * (CLK_HZ / 1000);
	localparam logic [2:0]  AVG_SEL_RESET   = 3'h2;
	localparam logic [2:0]  AVG_SEL_LP_MIN  = 3'h5;
	localparam logic [15:0] SAT_POS         = 16'h7FFF;
	localparam logic [15:0] SAT_NEG         = 16'h8000;
	localparam int          NV_COEF_COUNT   = 8;
	localparam int          NV_DEPTH        = 8;

	// one adc result; samples are 16-bit two's complement
	typedef struct packed {
		logic        valid;
		logic [15:0] data;
	} tca_sample_t;

	// request to and answer from the math engine
	typedef struct packed {
		logic        start;
		logic [15:0] die;
		logic [15:0] sensor;
	} tca_math_req_t;

	typedef struct packed {
		logic        done;
		logic [15:0] obj;
	} tca_math_rsp_t;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_CONVERT = 3'b001,
		ST_MATH    = 3'b010,
		ST_STANDBY = 3'b011,
		ST_WAIT    = 3'b100
	} tca_state_t;

endpackage

/* File: core/tca_conv_avg.sv */
// conversion sequencer with averaging, math hand-off and nv coefficient copy
// assumes adc front end, math engine and nv store are clocked by clk
//
// What this block does
// RULE1 - each nominal 250 ms cycle: get sensor and die values, compute, store three
// RULE2 - three-bit averaging field picks how many adc results are averaged
// RULE3 - after reset averaging field is 010, four conversions per second
// RULE4 - die result updates only after nth local conversion, holding their mean
// RULE5 - sensor result updates only after nth sensor conversion, holding their mean
// RULE6 - averaged values go to math engine which then updates object result
// RULE7 - codes 101, 110, 111 insert standby before the next conversion group
// RULE8 - nv coefficients copy to working registers singly or as a full set
// RULE9 - after reset each coefficient loads its most recently programmed nv value
// RULE10 - sensor result is 16-bit two's complement saturating at 7FFF and 8000
// RULE11 - temperature results are two's complement with 0.03125 degree steps
// RULE12 - each result register is written whole in a single clock edge
// RULE13 - averaging count per non-reset code is a design parameter
`timescale 1ns/1ps
module tca_conv_avg
	import tca_pkg::*;
#(
	parameter int             CYCLE_CLKS_P = CYCLE_CLKS,
	parameter int             STANDBY_CLKS = CYCLE_CLKS,
	parameter int             COEF_N       = NV_COEF_COUNT,
	parameter logic [63:0]    AVG_LOG2_MAP = 64'h0706050403020100
) (
	// clock and reset
	input  wire logic                clk,
	input  wire logic                rst,
	// averaging control
	input  wire logic [2:0]          avg_sel,
	// adc front end
	output tca_sample_t              unused_q,
	output logic                     adc_start_q,
	input  wire tca_sample_t         die_sample,
	input  wire tca_sample_t         sensor_sample,
	// math engine
	output tca_math_req_t            math_req_q,
	input  wire tca_math_rsp_t       math_rsp,
	// results
	output logic [15:0]              die_temperature_result_q,
	output logic [15:0]              sensor_voltage_result_q,
	output logic [15:0]              object_temperature_result_q,
	output logic                     results_valid_q,
	// nv coefficient store
	input  wire logic                nv_copy_one,
	input  wire logic                nv_copy_all,
	input  wire logic [2:0]          nv_index,
	output logic [2:0]               nv_rd_idx_q,
	input  wire logic [15:0]         nv_rd_data,
	output logic [COEF_N*16-1:0]     coef_q
);

	// refuse settings that the index and timer logic cannot serve
	if (COEF_N < 1 || COEF_N > NV_DEPTH) begin : g_bad_coef
		$error("COEF_N out of range");
	end
	if (CYCLE_CLKS_P < 2 || STANDBY_CLKS < 1) begin : g_bad_cycle
		$error("cycle counts too small");
	end

	// log2 of the averaging count for a field code
	function automatic logic [2:0] avg_log2(input logic [2:0] sel);
		avg_log2 = AVG_LOG2_MAP[{sel, 3'h0} +: 3]; // [RULE2] [RULE13]
	endfunction

	// stable avg_sel sampled twice since it comes from outside logic
	logic [2:0] sel_m_q, sel_s_q, cfg_sel_q;
	always_ff @(posedge clk) begin
		if (rst) begin
			sel_m_q <= AVG_SEL_RESET;
			sel_s_q <= AVG_SEL_RESET;
		end else begin
			sel_m_q <= avg_sel;
			sel_s_q <= sel_m_q;
		end
	end

	tca_state_t  state_q, state_d;
	logic [31:0] tmr_q;
	logic [7:0]  cnt_q;
	logic [23:0] die_acc_q, sen_acc_q;
	logic        die_got_q, sen_got_q;

	wire [2:0]  shift_w     = avg_log2(cfg_sel_q);
	wire [7:0]  n_w         = 8'(8'h1 << shift_w);
	wire        pair_w      = die_got_q && sen_got_q;
	wire        last_w      = pair_w && (cnt_q + 8'h1 == n_w);
	wire        lowpow_w    = cfg_sel_q >= AVG_SEL_LP_MIN; // [RULE7]
	wire        tmr_done_w  = tmr_q == 32'h0;
	wire [23:0] die_sum_w   = die_acc_q;
	wire [23:0] sen_sum_w   = sen_acc_q;
	// mean by arithmetic shift, sign kept [RULE4] [RULE5] [RULE11]
	wire signed [23:0] die_mean_w = $signed(die_sum_w) >>> shift_w;
	wire signed [23:0] sen_mean_w = $signed(sen_sum_w) >>> shift_w;
	// clip instead of wrap [RULE10]
	wire [15:0] sen_clip_w  = (sen_mean_w > 24'sd32767)  ? SAT_POS :
	                          (sen_mean_w < -24'sd32768) ? SAT_NEG : sen_mean_w[15:0];

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE:    state_d = ST_CONVERT;
			ST_CONVERT: if (last_w) state_d = ST_MATH;
			ST_MATH:    if (math_rsp.done) state_d = lowpow_w ? ST_STANDBY : ST_WAIT;
			ST_STANDBY: if (tmr_done_w) state_d = ST_CONVERT; // [RULE7]
			ST_WAIT:    if (tmr_done_w) state_d = ST_CONVERT; // [RULE1]
			default:    state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q   <= ST_IDLE;
			cfg_sel_q <= AVG_SEL_RESET; // [RULE3]
			tmr_q     <= 32'h0;
			cnt_q     <= 8'h0;
			die_acc_q <= 24'h0;
			sen_acc_q <= 24'h0;
			die_got_q <= 1'b0;
			sen_got_q <= 1'b0;
		end else begin
			state_q <= state_d;
			if (state_q == ST_IDLE || (state_q != ST_CONVERT && state_d == ST_CONVERT))
				cfg_sel_q <= sel_s_q;
			// period counter runs from group start; standby counts its own span
			if (state_q != ST_CONVERT && state_d == ST_CONVERT)
				tmr_q <= 32'(CYCLE_CLKS_P - 1); // [RULE1]
			else if (state_q == ST_MATH && state_d == ST_STANDBY)
				tmr_q <= 32'(STANDBY_CLKS - 1);
			else if (!tmr_done_w)
				tmr_q <= tmr_q - 32'h1;
			if (state_q == ST_CONVERT) begin
				// clear first so a sample landing with the pair still counts
				if (pair_w) begin
					die_got_q <= 1'b0;
					sen_got_q <= 1'b0;
					cnt_q     <= last_w ? 8'h0 : cnt_q + 8'h1;
				end
				if (die_sample.valid) begin
					die_acc_q <= die_acc_q + 24'($signed(die_sample.data));
					die_got_q <= 1'b1;
				end
				if (sensor_sample.valid) begin
					sen_acc_q <= sen_acc_q + 24'($signed(sensor_sample.data));
					sen_got_q <= 1'b1;
				end
			end else begin
				die_acc_q <= 24'h0;
				sen_acc_q <= 24'h0;
			end
		end
	end

	// adc start pulse at each conversion step
	always_ff @(posedge clk) begin
		if (rst) begin
			adc_start_q <= 1'b0;
			unused_q    <= '0;
		end else begin
			adc_start_q <= (state_q != ST_CONVERT && state_d == ST_CONVERT) ||
			               (state_q == ST_CONVERT && pair_w && !last_w);
			unused_q    <= '0;
		end
	end

	// results written whole on one edge; object after math finishes
	always_ff @(posedge clk) begin
		if (rst) begin
			die_temperature_result_q    <= 16'h0;
			sensor_voltage_result_q     <= 16'h0;
			object_temperature_result_q <= 16'h0;
			results_valid_q             <= 1'b0;
			math_req_q                  <= '0;
		end else begin
			math_req_q.start <= 1'b0;
			if (state_q == ST_CONVERT && last_w) begin
				die_temperature_result_q <= die_mean_w[15:0]; // [RULE4] [RULE12]
				sensor_voltage_result_q  <= sen_clip_w;       // [RULE5] [RULE12]
				math_req_q.start  <= 1'b1;                    // [RULE6]
				math_req_q.die    <= die_mean_w[15:0];
				math_req_q.sensor <= sen_clip_w;
			end
			if (state_q == ST_MATH && math_rsp.done) begin
				object_temperature_result_q <= math_rsp.obj; // [RULE6] [RULE12]
				results_valid_q             <= 1'b1;         // [RULE1]
			end
		end
	end

	// nv copy: after reset a full sweep, later single or full on request
	logic       nv_busy_q, nv_all_q, nv_pend_q;
	wire        nv_last_w   = nv_rd_idx_q == 3'(COEF_N - 1);
	// compared one bit wider so a full set of eight still accepts index 7
	wire        nv_one_ok_w = {1'b0, nv_index} < 4'(COEF_N);
	always_ff @(posedge clk) begin
		if (rst) begin
			nv_busy_q   <= 1'b1; // [RULE9]
			nv_all_q    <= 1'b1;
			nv_pend_q   <= 1'b0;
			nv_rd_idx_q <= 3'h0;
		end else if (!nv_busy_q) begin
			nv_pend_q <= 1'b0;
			if (nv_copy_all) begin // [RULE8]
				nv_busy_q   <= 1'b1;
				nv_all_q    <= 1'b1;
				nv_rd_idx_q <= 3'h0;
			end else if (nv_copy_one && nv_one_ok_w) begin // [RULE8]
				nv_busy_q   <= 1'b1;
				nv_all_q    <= 1'b0;
				nv_rd_idx_q <= nv_index;
			end
		end else begin
			// nv store answers one cycle after the index is presented,
			// so each location takes two edges: present, then capture
			nv_pend_q <= !nv_pend_q;
			if (nv_pend_q) begin
				if (!nv_all_q || nv_last_w)
					nv_busy_q <= 1'b0;
				else
					nv_rd_idx_q <= nv_rd_idx_q + 3'h1;
			end
		end
	end

	// nv store presents the last programmed value of each location
	genvar gi;
	generate
		for (gi = 0; gi < COEF_N; gi++) begin : g_coef
			always_ff @(posedge clk) begin
				if (rst)
					coef_q[gi*16 +: 16] <= 16'h0;
				else if (nv_busy_q && nv_pend_q && nv_rd_idx_q == 3'(gi))
					coef_q[gi*16 +: 16] <= nv_rd_data; // [RULE9] [RULE8]
			end
		end
	endgenerate

endmodule

/* File: verif/tca_conv_avg_checker.sv */
// port assertions for the conversion sequencer
// assumes a bind into tca_conv_avg, one clock domain, rst synchronous
`timescale 1ns/1ps
module tca_checker
	import tca_pkg::*;
(
	// clock and reset
	input wire logic          clk,
	input wire logic          rst,
	// watched ports
	input wire logic          adc_start_q,
	input wire tca_math_req_t math_req_q,
	input wire tca_math_rsp_t math_rsp,
	input wire logic [15:0]   die_temperature_result_q,
	input wire logic [15:0]   sensor_voltage_result_q,
	input wire logic [15:0]   object_temperature_result_q,
	input wire logic          results_valid_q
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	adc_pulse_a: assert property (adc_start_q |=> !adc_start_q)
		else $error("adc start longer than one cycle");
	math_pulse_a: assert property (math_req_q.start |=> !math_req_q.start)
		else $error("math start longer than one cycle");
	die_update_a: assert property ($changed(die_temperature_result_q) |-> math_req_q.start)
		else $error("die result moved outside group end");
	sensor_update_a: assert property ($changed(sensor_voltage_result_q) |-> math_req_q.start)
		else $error("sensor result moved outside group end");
	math_feed_a: assert property (math_req_q.start |-> math_req_q.die == die_temperature_result_q
		&& math_req_q.sensor == sensor_voltage_result_q) else $error("math fed other values");
	obj_load_a: assert property (math_rsp.done |=> object_temperature_result_q == $past(math_rsp.obj))
		else $error("object result not loaded");
	obj_whole_a: assert property ($changed(object_temperature_result_q) |-> $past(math_rsp.done))
		else $error("object result moved without answer");
	valid_hold_a: assert property (results_valid_q |=> results_valid_q)
		else $error("results valid dropped");
endmodule
bind tca_conv_avg tca_checker i_tca_checker (.clk, .rst, .adc_start_q, .math_req_q, .math_rsp,
	.die_temperature_result_q, .sensor_voltage_result_q, .object_temperature_result_q,
	.results_valid_q);

/* File: verif/tca_far_model.sv */
// adc front end, math engine and nv store around the sequencer
// assumes the sequencer's clock; adds value as die plus sensor in place of real math
`timescale 1ns/1ps
module tca_far_model
	import tca_pkg::*;
#(
	parameter logic [15:0] D0 = 16'h0320,
	parameter logic [15:0] D1 = 16'h0340,
	parameter logic [15:0] S0 = 16'h7FF0,
	parameter logic [15:0] S1 = 16'h7FFE
) (
	// clock and reset
	input  wire logic          clk,
	input  wire logic          rst,
	// adc and math
	input  wire logic          adc_start_q,
	input  wire tca_math_req_t math_req_q,
	output tca_sample_t        die_sample,
	output tca_sample_t        sensor_sample,
	output tca_math_rsp_t      math_rsp,
	// nv store
	input  wire logic [2:0]    nv_rd_idx_q,
	input  wire logic [15:0]   nv_base,
	output logic [15:0]        nv_rd_data
);
	logic [2:0]  sh_q;
	logic [2:0]  msh_q;
	logic        first_q;
	logic [15:0] obj_q;
	// samples alternate between the two values from each group start, so an odd-sized group shows in the mean
	assign die_sample    = {sh_q[1], sh_q[1] ? (first_q ? D0 : D1) : ~D0};
	assign sensor_sample = {sh_q[2], sh_q[2] ? (first_q ? S0 : S1) : ~S0};
	assign math_rsp      = {msh_q[2], msh_q[2] ? obj_q : ~obj_q};
	always_ff @(posedge clk) begin
		sh_q <= {sh_q[1:0], adc_start_q};
		msh_q <= {msh_q[1:0], math_req_q.start};
		if (math_req_q.start) obj_q <= math_req_q.die + math_req_q.sensor;
		if (rst || math_req_q.start) first_q <= 1'b1;
		else if (sh_q[2]) first_q <= ~first_q;
		nv_rd_data <= nv_base + 16'(nv_rd_idx_q);
	end
endmodule

/* File: verif/test_thermopile_conversion_averaging.sv */
// self-checking bench for the conversion sequencer
// assumes tca_far_model answers adc, math and nv requests
`timescale 1ns/1ps
module test_thermopile_conversion_averaging
	import tca_pkg::*;
;
	localparam logic [15:0] DM = 16'h0330;
	localparam logic [15:0] SM = 16'h7FF7;
	logic          clk = 1'b0, rst = 1'b1, nv_copy_one = 1'b0, nv_copy_all = 1'b0;
	logic [2:0]    avg_sel = AVG_SEL_RESET, nv_index = 3'h0;
	logic [15:0]   nv_base = 16'hA000;
	wire logic     adc_start_q, results_valid_q;
	wire logic [15:0] die_r, sen_r, obj_r, nv_rd_data;
	wire logic [2:0] nv_rd_idx_q;
	wire logic [127:0] coef_q;
	wire tca_sample_t die_sample, sensor_sample;
	wire tca_math_req_t math_req_q;
	wire tca_math_rsp_t math_rsp;
	wire tca_sample_t spare_w;
	int fail_count = 0, checks = 0;
	tca_conv_avg #(.CYCLE_CLKS_P(200), .STANDBY_CLKS(50)) i_tca_conv_avg (.clk, .rst, .avg_sel,
		.unused_q(spare_w), .adc_start_q, .die_sample, .sensor_sample, .math_req_q, .math_rsp,
		.die_temperature_result_q(die_r), .sensor_voltage_result_q(sen_r),
		.object_temperature_result_q(obj_r), .results_valid_q, .nv_copy_one, .nv_copy_all,
		.nv_index, .nv_rd_idx_q, .nv_rd_data, .coef_q);
	tca_far_model i_tca_far_model (.clk, .rst, .adc_start_q, .math_req_q, .die_sample,
		.sensor_sample, .math_rsp, .nv_rd_idx_q, .nv_base, .nv_rd_data);
	initial forever #25 clk = ~clk;
	task chk(input logic ok, input string m);
		checks++;
		if (ok !== 1'b1) begin
			fail_count++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task wait_done(output int n);
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
			if (n > 3000) begin
				fail_count++;
				$display("[FAIL] %0t math answer timeout", $time);
				stop_test;
			end
		end while (math_rsp.done !== 1'b1);
	endtask
	// the first group after reset runs the reset code whatever the pin holds
	task test_boot(input logic [15:0] b);
		int t, k;
		@(posedge clk) rst <= 1'b1;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		t = 0;
		k = 0;
		do begin
			@(posedge clk);
			#1;
			t++;
			if (adc_start_q === 1'b1) k++;
			if (t > 3000) begin
				fail_count++;
				$display("[FAIL] %0t boot group timeout", $time);
				stop_test;
			end
		end while (math_rsp.done !== 1'b1);
		chk(k == (1 << AVG_SEL_RESET), "reset code pairs");
		for (int i = 0; i < 8; i++) chk(coef_q[16*i+:16] === b + 16'(i), "boot coef");
		chk(spare_w === '0, "spare zero");
		$display("boot done");
	endtask
	// the reset code comes first, so the default mode is judged on its own
	task test_modes;
		int n, k, g, t;
		for (int j = 0; j < 9; j++) begin
			@(posedge clk) avg_sel <= (j == 0) ? AVG_SEL_RESET : 3'(j + 1);
			wait_done(n);
			wait_done(n);
			g = 0;
			while (adc_start_q !== 1'b1 && g < 3000) begin
				@(posedge clk);
				#1;
				g++;
			end
			k = 0;
			t = 0;
			while (math_rsp.done !== 1'b1 && t < 3000) begin
				if (adc_start_q === 1'b1) k++;
				@(posedge clk);
				#1;
				t++;
			end
			if (g >= 3000 || t >= 3000) begin
				fail_count++;
				$display("[FAIL] %0t conversion group timeout", $time);
				stop_test;
			end
			chk(k == (1 << avg_sel), "pair count");
			if (avg_sel >= AVG_SEL_LP_MIN) chk(g >= 50, "standby gap");
			@(posedge clk);
			#1;
			chk(die_r === ((avg_sel == 3'h0) ? 16'h0320 : DM), "die mean");
			chk(sen_r === ((avg_sel == 3'h0) ? 16'h7FF0 : SM), "sensor mean");
			chk(obj_r === die_r + sen_r, "object result");
			chk(results_valid_q === 1'b1, "results valid");
		end
		$display("modes done");
	endtask
	task test_nv;
		@(posedge clk) {nv_base, nv_index, nv_copy_one} <= {16'hB000, 3'h3, 1'b1};
		@(posedge clk) nv_copy_one <= 1'b0;
		repeat (20) @(posedge clk);
		#1;
		chk(coef_q[63:48] === 16'hB003 && coef_q[47:32] === 16'hA002, "copy one");
		@(posedge clk) nv_copy_all <= 1'b1;
		@(posedge clk) nv_copy_all <= 1'b0;
		repeat (30) @(posedge clk);
		#1;
		for (int i = 0; i < 8; i++) chk(coef_q[16*i+:16] === 16'hB000 + 16'(i), "copy all");
		$display("nv done");
	endtask
	initial begin
		test_boot(16'hA000);
		test_nv;
		test_modes;
		test_boot(16'hB000);
		stop_test;
	end
endmodule
